/* File: src/i2css_defs.vh */
// offsets, field layouts, reset values for the spike suppression block
`ifndef I2CSS_DEFS_VH
`define I2CSS_DEFS_VH

`define I2CSS_ADDR_W 8
`define I2CSS_DATA_W 32
`define I2CSS_LIMIT_W 8

`define I2CSS_OFS_CONTROL_REGISTER_ONE 8'h00
`define I2CSS_OFS_STATUS 8'h04
`define I2CSS_OFS_STD_LIMIT 8'h0a
`define I2CSS_OFS_HS_LIMIT 8'ha4

`define I2CSS_CONTROL_REGISTER_ONE_EN_BIT 0
`define I2CSS_CONTROL_REGISTER_ONE_RESET 1'h0

`define I2CSS_ST_SCL_BIT 0
`define I2CSS_ST_SDA_BIT 1
`define I2CSS_ST_HS_BIT 2
`define I2CSS_ST_REFUSED_BIT 3

`define I2CSS_STD_LIMIT_RESET 8'h05
`define I2CSS_HS_LIMIT_RESET 8'h01
`define I2CSS_LIMIT_MIN 8'h01

`define I2CSS_LINE_IDLE 1'h1

`endif

/* File: src/i2css_line_filter.v */
// one bus line: two-stage synchroniser and spike-suppression counter
`timescale 1ns/1ps
`include "i2css_defs.vh"

module i2css_line_filter #(
	parameter LIMIT_W = `I2CSS_LIMIT_W
) (
	input wire clk_i,
	input wire rstn_i,
	input wire line_i,
	input wire [LIMIT_W-1:0] limit_i,
	output wire line_o
);

	reg meta_reg;
	reg sync_reg;
	reg out_reg;
	reg [LIMIT_W-1:0] cnt_reg;

	// first stage is read by the second stage only
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_reg <= `I2CSS_LINE_IDLE;
			sync_reg <= `I2CSS_LINE_IDLE;
		end else begin
			meta_reg <= line_i;
			sync_reg <= meta_reg;
		end
	end

	// output follows only after limit+1 differing samples in a row
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			out_reg <= `I2CSS_LINE_IDLE;
			cnt_reg <= {LIMIT_W{1'b0}};
		end else if (sync_reg == out_reg) begin
			cnt_reg <= {LIMIT_W{1'b0}};
		end else if (cnt_reg >= limit_i) begin
			out_reg <= sync_reg;
			cnt_reg <= {LIMIT_W{1'b0}};
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign line_o = out_reg;

endmodule

/* File: src/i2css_top.v */
// spike suppression for the serial clock and data lines, with registers
//
// Overview of operation
// - drop pulses not longer than the limit
// - standard/fast limit, bits 7:0, resets 0x05
// - high-speed limit, bits 7:0, resets 0x01
// - both limits writable only while disabled
// - accepted write below one stores one
`timescale 1ns/1ps
`include "i2css_defs.vh"

module i2css_top #(
	parameter ADDR_W = `I2CSS_ADDR_W,
	parameter DATA_W = `I2CSS_DATA_W,
	parameter LIMIT_W = `I2CSS_LIMIT_W
) (
	input wire SYS_CLK_I,
	input wire RSTN_I,
	input wire [ADDR_W-1:0] ADDR_I,
	input wire [DATA_W-1:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output wire [DATA_W-1:0] RDATA_O,
	input wire SCL_I,
	input wire SDA_I,
	input wire HS_MODE_I,
	output wire SCL_FILT_O,
	output wire SDA_FILT_O,
	output wire IF_EN_O
);

	reg interface_enable_reg;
	reg [LIMIT_W-1:0] std_fast_spike_limit_reg;
	reg [LIMIT_W-1:0] high_speed_spike_limit_reg;
	reg refused_reg;
	reg refused_next;
	reg [DATA_W-1:0] rdata_reg;
	reg [DATA_W-1:0] rdata_next;
	reg [LIMIT_W-1:0] wr_limit;
	reg interface_enable_next;
	reg [LIMIT_W-1:0] std_fast_spike_limit_next;
	reg [LIMIT_W-1:0] high_speed_spike_limit_next;
	reg [LIMIT_W-1:0] active_limit;
	reg [DATA_W-1:0] ctrl_word;
	reg [DATA_W-1:0] status_word;
	reg [DATA_W-1:0] std_word;
	reg [DATA_W-1:0] hs_word;

	wire sel_ctrl;
	wire sel_status;
	wire sel_std;
	wire sel_hs;
	wire limit_write;
	wire limit_ok;
	wire wr_ctrl;
	wire wr_std;
	wire wr_hs;
	wire rd_status;
	wire limit_refused;
	wire [LIMIT_W-1:0] wr_field;
	wire [1:0] raw_lines;
	wire [1:0] filt_lines;

	assign sel_ctrl = (ADDR_I == `I2CSS_OFS_CONTROL_REGISTER_ONE);
	assign sel_status = (ADDR_I == `I2CSS_OFS_STATUS);
	assign sel_std = (ADDR_I == `I2CSS_OFS_STD_LIMIT);
	assign sel_hs = (ADDR_I == `I2CSS_OFS_HS_LIMIT);

	assign limit_write = WR_I && (sel_std || sel_hs);
	// limits are frozen while the interface runs, so the filter never
	// sees a register write change its threshold in the middle of a transfer; a HS_MODE_I switch still does
	assign limit_ok = !interface_enable_reg;

	// one strobe per register; decodes are exact, so a write to an
	// unmapped address selects nothing and is lost
	assign wr_ctrl = WR_I && sel_ctrl;
	assign wr_std = WR_I && sel_std && limit_ok;
	assign wr_hs = WR_I && sel_hs && limit_ok;
	assign rd_status = RD_I && sel_status;
	assign limit_refused = limit_write && !limit_ok;
	assign wr_field = WDATA_I[LIMIT_W-1:0];

	// zero would let every glitch through, so it is raised to one
	always @* begin
		if (wr_field < `I2CSS_LIMIT_MIN)
			wr_limit = `I2CSS_LIMIT_MIN;
		else
			wr_limit = wr_field;
	end

	// a register keeps its value unless its own strobe is up; a refused
	// limit write leaves the old limit in place
	always @* begin
		interface_enable_next = interface_enable_reg;
		std_fast_spike_limit_next = std_fast_spike_limit_reg;
		high_speed_spike_limit_next = high_speed_spike_limit_reg;
		if (wr_ctrl)
			interface_enable_next = WDATA_I[`I2CSS_CONTROL_REGISTER_ONE_EN_BIT];
		if (wr_std)
			std_fast_spike_limit_next = wr_limit;
		if (wr_hs)
			high_speed_spike_limit_next = wr_limit;
	end

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I)
			interface_enable_reg <= `I2CSS_CONTROL_REGISTER_ONE_RESET;
		else
			interface_enable_reg <= interface_enable_next;
	end

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I)
			std_fast_spike_limit_reg <= `I2CSS_STD_LIMIT_RESET;
		else
			std_fast_spike_limit_reg <= std_fast_spike_limit_next;
	end

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I)
			high_speed_spike_limit_reg <= `I2CSS_HS_LIMIT_RESET;
		else
			high_speed_spike_limit_reg <= high_speed_spike_limit_next;
	end

	// sticky flag for a discarded limit write; a new refusal in the
	// same cycle as the status read that clears it is kept
	always @* begin
		refused_next = refused_reg;
		if (rd_status)
			refused_next = 1'b0;
		if (limit_refused)
			refused_next = 1'b1;
	end

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I)
			refused_reg <= 1'b0;
		else
			refused_reg <= refused_next;
	end

	// reserved bits of every word read as zero
	always @* begin
		ctrl_word = {DATA_W{1'b0}};
		status_word = {DATA_W{1'b0}};
		std_word = {DATA_W{1'b0}};
		hs_word = {DATA_W{1'b0}};
		ctrl_word[`I2CSS_CONTROL_REGISTER_ONE_EN_BIT] = interface_enable_reg;
		status_word[`I2CSS_ST_SCL_BIT] = filt_lines[0];
		status_word[`I2CSS_ST_SDA_BIT] = filt_lines[1];
		status_word[`I2CSS_ST_HS_BIT] = HS_MODE_I;
		status_word[`I2CSS_ST_REFUSED_BIT] = refused_reg;
		std_word[LIMIT_W-1:0] = std_fast_spike_limit_reg;
		hs_word[LIMIT_W-1:0] = high_speed_spike_limit_reg;
	end

	// read data stand only in the cycle after the read strobe
	always @* begin
		rdata_next = {DATA_W{1'b0}};
		if (RD_I) begin
			case (ADDR_I)
				`I2CSS_OFS_CONTROL_REGISTER_ONE: begin
					rdata_next = ctrl_word;
				end
				`I2CSS_OFS_STATUS: begin
					rdata_next = status_word;
				end
				`I2CSS_OFS_STD_LIMIT: begin
					rdata_next = std_word;
				end
				`I2CSS_OFS_HS_LIMIT: begin
					rdata_next = hs_word;
				end
				default: begin
					rdata_next = {DATA_W{1'b0}};
				end
			endcase
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I)
			rdata_reg <= {DATA_W{1'b0}};
		else
			rdata_reg <= rdata_next;
	end

	// mode comes from the controller core on this clock, no sync needed;
	// a switch in mid-count keeps the count, so an edge in flight is
	// judged against the new limit
	always @* begin
		if (HS_MODE_I)
			active_limit = high_speed_spike_limit_reg;
		else
			active_limit = std_fast_spike_limit_reg;
	end

	assign raw_lines = {SDA_I, SCL_I};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
			i2css_line_filter #(
				.LIMIT_W(LIMIT_W)
			) u_filt (
				.clk_i(SYS_CLK_I),
				.rstn_i(RSTN_I),
				.line_i(raw_lines[gi]),
				.limit_i(active_limit),
				.line_o(filt_lines[gi])
			);
		end
	endgenerate

	assign RDATA_O = rdata_reg;
	assign SCL_FILT_O = filt_lines[0];
	assign SDA_FILT_O = filt_lines[1];
	assign IF_EN_O = interface_enable_reg;

endmodule

/* File: dv/i2css_bus_model.sv */
// model of the two pulled-up bus lines
`timescale 1ns/1ps
module i2css_bus_model (
	input wire clk_i,
	output logic scl_o,
	output logic sda_o
);
	initial scl_o = 1'h1;
	initial sda_o = 1'h1;
	task pulse(input int n);
		@(posedge clk_i);
		scl_o <= 1'h0;
		sda_o <= 1'h0;
		repeat (n) @(posedge clk_i);
		// released lines go back high through the pull-up
		scl_o <= 1'h1;
		sda_o <= 1'h1;
	endtask
endmodule

/* File: dv/i2css_top_sva.sv */
// port checker for the spike suppression block
`timescale 1ns/1ps
module i2css_top_sva (
	input wire SYS_CLK_I,
	input wire RSTN_I,
	input wire [7:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	input wire [31:0] RDATA_O,
	input wire SCL_I,
	input wire HS_MODE_I,
	input wire SCL_FILT_O,
	input wire IF_EN_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence s_zero_wr;
		WR_I && ADDR_I == 8'h0a && !IF_EN_O && WDATA_I == 32'h0;
	endsequence
	sequence s_rd_std;
		RD_I && ADDR_I == 8'h0a;
	endsequence
	a_min_store: assert property (s_zero_wr ##1 !WR_I ##1 s_rd_std
		|=> RDATA_O == 32'h1) else $error("zero write not raised to one");
	a_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data outside read slot");
	// limit of at least one: pin must have held for at least two cycles, seen three and four cycles back through two sync flops
	// output is unknown before the first reset edge: skip that first step
	a_fall_filter: assert property ($fell(SCL_FILT_O)
		&& $past(RSTN_I)
		|-> !$past(SCL_I, 3) && !$past(SCL_I, 4)) else $error("short low passed");
	a_rise_filter: assert property ($rose(SCL_FILT_O)
		&& $past(RSTN_I)
		|-> $past(SCL_I, 3) && $past(SCL_I, 4)) else $error("short high passed");
	a_limit_range: assert property (RD_I && (ADDR_I == 8'h0a
		|| ADDR_I == 8'ha4) |=> RDATA_O[31:8] == 24'h0 && RDATA_O[7:0] != 8'h0)
		else $error("limit out of range");
	a_en_write: assert property (WR_I && ADDR_I == 8'h00
		|=> IF_EN_O == $past(WDATA_I[0])) else $error("enable not written");
	a_en_hold: assert property (!(WR_I && ADDR_I == 8'h00)
		|=> $stable(IF_EN_O)) else $error("enable changed");
	a_status_hs: assert property (RD_I && ADDR_I == 8'h04
		|=> RDATA_O[2] == $past(HS_MODE_I) && RDATA_O[31:4] == 28'h0)
		else $error("status mode bit wrong");
endmodule
bind i2css_top i2css_top_sva u_sva (.SYS_CLK_I, .RSTN_I, .ADDR_I, .WDATA_I,
	.WR_I, .RD_I, .RDATA_O, .SCL_I, .HS_MODE_I, .SCL_FILT_O, .IF_EN_O);

/* File: dv/tb_top.sv */
// self-checking bench for the spike suppression block
`timescale 1ns/1ps
module tb_top;
	logic SYS_CLK_I = 0, RSTN_I = 0, WR_I = 0, RD_I = 0, HS_MODE_I = 0;
	logic [7:0] ADDR_I = 8'h0;
	logic [31:0] WDATA_I = 32'h0;
	wire [31:0] RDATA_O;
	wire SCL_I, SDA_I, SCL_FILT_O, SDA_FILT_O, IF_EN_O;
	logic [1:0] lo;
	logic lo_clr = 0;
	int n_mismatch = 0, compares = 0;
	always #5 SYS_CLK_I = ~SYS_CLK_I;
	always @(posedge SYS_CLK_I)
		lo <= lo_clr ? 2'h0 : lo | {!SDA_FILT_O, !SCL_FILT_O};
	i2css_bus_model bus (.clk_i(SYS_CLK_I), .scl_o(SCL_I), .sda_o(SDA_I));
	i2css_top dut (.SYS_CLK_I, .RSTN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
		.RDATA_O, .SCL_I, .SDA_I, .HS_MODE_I, .SCL_FILT_O, .SDA_FILT_O,
		.IF_EN_O);
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// idle cycle after each access keeps strobes single-assigned
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		WR_I <= w;
		RD_I <= !w;
		ADDR_I <= a;
		WDATA_I <= d;
		@(posedge SYS_CLK_I);
		WR_I <= 1'h0;
		RD_I <= 1'h0;
		@(posedge SYS_CLK_I);
		if (!w) check(RDATA_O, d);
	endtask
	task spike(input int n, input logic [1:0] e);
		lo_clr <= 1'h1;
		@(posedge SYS_CLK_I);
		lo_clr <= 1'h0;
		bus.pulse(n);
		repeat (14) @(posedge SYS_CLK_I);
		check({30'h0, lo}, {30'h0, e});
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge SYS_CLK_I);
		RSTN_I <= 1'h1;
		acc(0, 8'h0a, 32'h5);
		acc(0, 8'ha4, 32'h1);
		acc(0, 8'h10, 32'h0);
		acc(1, 8'h0a, 32'h0);
		acc(0, 8'h0a, 32'h1);
		acc(1, 8'ha4, 32'h0);
		acc(0, 8'ha4, 32'h1);
		acc(1, 8'h0a, 32'hffff_ff07);
		acc(0, 8'h0a, 32'h7);
		acc(1, 8'ha4, 32'h3);
		acc(0, 8'ha4, 32'h3);
		$display("test 1 done");
		acc(1, 8'h00, 32'h1);
		check({31'h0, IF_EN_O}, 32'h1);
		acc(0, 8'h00, 32'h1);
		acc(1, 8'h0a, 32'h9);
		acc(1, 8'ha4, 32'h0);
		acc(0, 8'h0a, 32'h7);
		acc(0, 8'ha4, 32'h3);
		acc(1, 8'h00, 32'h0);
		acc(0, 8'h00, 32'h0);
		acc(0, 8'h04, 32'hb);
		acc(0, 8'h04, 32'h3);
		$display("test 2 done");
		for (int h = 0; h < 2; h++) begin
			HS_MODE_I <= h[0];
			spike(h ? 3 : 7, 2'h0);
			spike(h ? 4 : 8, 2'h3);
		end
		$display("test 3 done");
		close_out();
	end
endmodule
